// ---- inherent_mode_bus_sequencer.sv ----
// Bus-cycle sequencer for inherent-mode instructions
`timescale 1ns/1ps
//Contract
//- simple inherent ops run two reads: opcode, then next opcode at address plus one
//- index/double-shift/copy-to-stack ops take three cycles, third reads FFFF
//- second-cycle data meaning per op; third-cycle data is restart vector low byte
//- stack pointer step ops take three reads, third at old stack pointer
//- accumulator push: two reads then write of accumulator at stack pointer
//- stack-to-index copy: three reads, third at stack pointer, data dropped
//- accumulator pull: four reads, dummy at stack pointer, data at plus one
//- index push: two reads, low byte at stack pointer, high at minus one
//- index pull: five reads, high byte at plus one, low at plus two
//- subroutine return: five reads, return address from plus one and plus two
//- wait takes nine cycles, return address written at stack pointer and minus one
//- wait then writes index, A, B, flags at stack pointer minus two to six
//- halted wait repeats reads at original stack pointer minus seven, never floats
module inherent_mode_bus_sequencer
	import inherent_seq_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       startReq,
	input  inst_kind_t      startKind,
	input  cpu_regs_t       startRegs,
	input  wire logic [7:0] busDataIn,
	input  wire logic       wakeReq,
	output bus_cycle_t      busOut,
	output logic            readyOut,
	output logic            doneOut,
	output cpu_regs_t       regsOut
);

	typedef enum logic [1:0] {IDLE, RUN, HALT} seq_state_t;

	seq_state_t  stateReg, stateNext;
	inst_kind_t  kindReg, kindNext;
	logic [3:0]  stepReg, stepNext;
	logic [15:0] baseReg, baseNext;
	cpu_regs_t   workReg, workNext;
	bus_cycle_t  busReg, busNext;
	logic        doneReg, doneNext;
	logic        readyReg, readyNext;

	function automatic logic [3:0] lastCycle(input inst_kind_t k);
		unique case (k)
			SIMPLE_INHERENT:                       lastCycle = CYC_SIMPLE;
			PULL_ACC_A, PULL_ACC_B, PUSH_INDEX:    lastCycle = CYC_FOUR;
			PULL_INDEX, RETURN_FROM_SUBROUTINE:    lastCycle = CYC_FIVE;
			WAIT_FOR_INTERRUPT:                    lastCycle = CYC_WAIT;
			default:                               lastCycle = CYC_THREE;
		endcase
	endfunction

	always_comb begin
		logic [15:0] offs;
		logic [3:0]  s;
		offs      = 16'h0000;
		s         = 4'(stepReg + 4'h1);
		stateNext = stateReg;
		kindNext  = kindReg;
		stepNext  = stepReg;
		baseNext  = baseReg;
		workNext  = workReg;
		busNext   = busReg;
		busNext.rw   = 1'b1;
		busNext.oe   = 1'b0;
		busNext.data = RESET_DATA;
		doneNext  = 1'b0;
		unique case (stateReg)
			IDLE: begin
				if (startReq) begin
					kindNext     = startKind;
					baseNext     = startRegs.sp;
					workNext     = startRegs;
					stepNext     = STEP_FIRST;
					busNext.addr = startRegs.pc;
					stateNext    = RUN;
				end
			end
			RUN: begin
				// Effects of the cycle now ending
				if (stepReg == STEP_FIRST)
					workNext.pc = 16'(workReg.pc + 16'h0001);
				unique case (kindReg)
					STACK_POINTER_INCREMENT: if (stepReg == CYC_THREE) workNext.sp = 16'(workReg.sp + 16'h0001);
					STACK_POINTER_DECREMENT: if (stepReg == CYC_THREE) workNext.sp = 16'(workReg.sp - 16'h0001);
					PUSH_ACC_A, PUSH_ACC_B: if (stepReg == CYC_THREE) workNext.sp = 16'(workReg.sp - 16'h0001);
					PUSH_INDEX, WAIT_FOR_INTERRUPT: if (stepReg >= CYC_THREE)
						workNext.sp = 16'(workReg.sp - 16'h0001);
					PULL_ACC_A: if (stepReg == CYC_FOUR) begin
						workNext.a  = busDataIn;
						workNext.sp = 16'(workReg.sp + 16'h0001);
					end
					PULL_ACC_B: if (stepReg == CYC_FOUR) begin
						workNext.b  = busDataIn;
						workNext.sp = 16'(workReg.sp + 16'h0001);
					end
					PULL_INDEX: if (stepReg >= CYC_FOUR) begin
						if (stepReg == CYC_FOUR)
							workNext.x[15:8] = busDataIn;
						else
							workNext.x[7:0] = busDataIn;
						workNext.sp = 16'(workReg.sp + 16'h0001);
					end
					RETURN_FROM_SUBROUTINE: if (stepReg >= CYC_FOUR) begin
						if (stepReg == CYC_FOUR)
							workNext.pc[15:8] = busDataIn;
						else
							workNext.pc[7:0] = busDataIn;
						workNext.sp = 16'(workReg.sp + 16'h0001);
					end
					ADD_B_TO_INDEX: if (stepReg == CYC_THREE) workNext.x = 16'(workReg.x + {8'h00, workReg.b});
					DOUBLE_ACC_SHIFT_LEFT: if (stepReg == CYC_THREE) {workNext.a, workNext.b} = {workReg.a[6:0], workReg.b, 1'b0};
					DOUBLE_ACC_SHIFT_RIGHT: if (stepReg == CYC_THREE) {workNext.a, workNext.b} = {1'b0, workReg.a, workReg.b[7:1]};
					INDEX_INCREMENT: if (stepReg == CYC_THREE) workNext.x = 16'(workReg.x + 16'h0001);
					INDEX_DECREMENT: if (stepReg == CYC_THREE) workNext.x = 16'(workReg.x - 16'h0001);
					INDEX_TO_STACK_COPY: if (stepReg == CYC_THREE) workNext.sp = 16'(workReg.x - STACK_COPY_ADJ);
					STACK_TO_INDEX_COPY: if (stepReg == CYC_THREE) workNext.x = 16'(workReg.sp + STACK_COPY_ADJ);
					default: ;
				endcase
				if (stepReg == lastCycle(kindReg)) begin
					if (kindReg == WAIT_FOR_INTERRUPT) begin
						stateNext    = HALT;
						busNext.addr = 16'(baseReg - HALT_STACK_DROP);
					end else begin
						stateNext = IDLE;
						doneNext  = 1'b1;
					end
				end else begin
					stepNext = s;
					offs     = 16'({12'h000, s} - PULL_OFFSET_BASE);
					if (s == CYC_SIMPLE)
						busNext.addr = 16'(workReg.pc + 16'h0001);
					else begin
						unique case (kindReg)
							PUSH_ACC_A, PUSH_ACC_B: begin
								busNext.addr = baseReg;
								busNext.rw   = 1'b0;
								busNext.oe   = 1'b1;
								busNext.data = (kindReg == PUSH_ACC_A) ? workReg.a : workReg.b;
							end
							PUSH_INDEX, WAIT_FOR_INTERRUPT: begin
								busNext.addr = 16'(baseReg - offs);
								busNext.rw   = 1'b0;
								busNext.oe   = 1'b1;
								unique case (s)
									4'h3: busNext.data = (kindReg == PUSH_INDEX) ? workReg.x[7:0] : workNext.pc[7:0];
									4'h4: busNext.data = (kindReg == PUSH_INDEX) ? workReg.x[15:8] : workNext.pc[15:8];
									4'h5: busNext.data = workReg.x[7:0];
									4'h6: busNext.data = workReg.x[15:8];
									4'h7: busNext.data = workReg.a;
									4'h8: busNext.data = workReg.b;
									default: busNext.data = workReg.cc;
								endcase
							end
							STACK_POINTER_INCREMENT, STACK_POINTER_DECREMENT, STACK_TO_INDEX_COPY,
							PULL_ACC_A, PULL_ACC_B, PULL_INDEX, RETURN_FROM_SUBROUTINE:
								busNext.addr = 16'(baseReg + offs);
							default:
								busNext.addr = IDLE_VECTOR_ADDR;
						endcase
					end
				end
			end
			HALT: begin
				busNext.addr = 16'(baseReg - HALT_STACK_DROP);
				if (wakeReq) begin
					stateNext = IDLE;
					doneNext  = 1'b1;
				end
			end
		endcase
		readyNext = (stateNext == IDLE);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stateReg <= IDLE;
			kindReg  <= SIMPLE_INHERENT;
			stepReg  <= STEP_RESET;
			baseReg  <= RESET_ADDR;
			workReg  <= '0;
			busReg   <= '{addr: RESET_ADDR, rw: 1'b1, oe: 1'b0, data: RESET_DATA};
			doneReg  <= 1'b0;
			readyReg <= 1'b1;
		end else begin
			stateReg <= stateNext;
			kindReg  <= kindNext;
			stepReg  <= stepNext;
			baseReg  <= baseNext;
			workReg  <= workNext;
			busReg   <= busNext;
			doneReg  <= doneNext;
			readyReg <= readyNext;
		end
	end

	assign busOut   = busReg;
	assign readyOut = readyReg;
	assign doneOut  = doneReg;
	assign regsOut  = workReg;

	logic taken;
	assign taken = startReq && (stateReg == IDLE);

	sequence s_two_reads(logic [15:0] pcFirst, logic [15:0] pcSecond);
		(busReg.rw && busReg.addr == pcFirst) ##1 (busReg.rw && busReg.addr == 16'(pcSecond + 16'h0001));
	endsequence

	property p_simple;
		@(posedge ref_clk) disable iff (!rst_n)
		taken && startKind == SIMPLE_INHERENT |=> s_two_reads($past(startRegs.pc), $past(startRegs.pc, 2)) ##1 doneReg;
	endproperty
	a_simple: assert property (p_simple) else $error("simple op sequence wrong");

	property p_ffff_third;
		@(posedge ref_clk) disable iff (!rst_n)
		taken && startKind inside {ADD_B_TO_INDEX, DOUBLE_ACC_SHIFT_LEFT, DOUBLE_ACC_SHIFT_RIGHT,
			INDEX_INCREMENT, INDEX_DECREMENT, INDEX_TO_STACK_COPY}
		|=> ##2 (busReg.rw && busReg.addr == IDLE_VECTOR_ADDR) ##1 doneReg;
	endproperty
	a_ffff_third: assert property (p_ffff_third) else $error("third cycle not FFFF read");

	property p_sp_step;
		@(posedge ref_clk) disable iff (!rst_n)
		taken && startKind inside {STACK_POINTER_INCREMENT, STACK_POINTER_DECREMENT, STACK_TO_INDEX_COPY}
		|=> ##2 (busReg.rw && busReg.addr == $past(startRegs.sp, 3)) ##1 doneReg;
	endproperty
	a_sp_step: assert property (p_sp_step) else $error("stack read cycle wrong");

	property p_push_acc;
		@(posedge ref_clk) disable iff (!rst_n)
		taken && startKind == PUSH_ACC_B
		|=> ##2 (!busReg.rw && busReg.oe && busReg.addr == $past(startRegs.sp, 3) && busReg.data == $past(startRegs.b, 3));
	endproperty
	a_push_acc: assert property (p_push_acc) else $error("accumulator push write wrong");

	property p_pull_acc;
		@(posedge ref_clk) disable iff (!rst_n)
		taken && startKind == PULL_ACC_A
		|=> ##3 (busReg.rw && busReg.addr == 16'($past(startRegs.sp, 4) + 16'h0001)) ##1 (doneReg && regsOut.a == $past(busDataIn));
	endproperty
	a_pull_acc: assert property (p_pull_acc) else $error("accumulator pull wrong");

	property p_push_index;
		@(posedge ref_clk) disable iff (!rst_n)
		taken && startKind == PUSH_INDEX |=> ##2 (!busReg.rw && busReg.data == $past(startRegs.x[7:0], 3))
			##1 (!busReg.rw && busReg.addr == 16'($past(startRegs.sp, 4) - 16'h0001))
			##1 (doneReg && regsOut.sp == 16'($past(startRegs.sp, 5) - 16'h0002));
	endproperty
	a_push_index: assert property (p_push_index) else $error("index push wrong");

	property p_return;
		@(posedge ref_clk) disable iff (!rst_n)
		taken && startKind == RETURN_FROM_SUBROUTINE
		|=> ##4 (busReg.addr == 16'($past(startRegs.sp, 5) + 16'h0002)) ##1 (doneReg && regsOut.pc[7:0] == $past(busDataIn));
	endproperty
	a_return: assert property (p_return) else $error("return address wrong");

	property p_wait_len;
		@(posedge ref_clk) disable iff (!rst_n)
		taken && startKind == WAIT_FOR_INTERRUPT |=> ##2 (!busReg.rw)[*7] ##1 (stateReg == HALT);
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("wait write phase wrong");

	property p_halt_bus;
		@(posedge ref_clk) disable iff (!rst_n)
		stateReg == HALT |-> busReg.rw && !busReg.oe && busReg.addr == 16'(baseReg - HALT_STACK_DROP);
	endproperty
	a_halt_bus: assert property (p_halt_bus) else $error("halted bus wrong");

	property p_write_only_push;
		@(posedge ref_clk) disable iff (!rst_n)
		!busReg.rw |-> busReg.oe && kindReg inside {PUSH_ACC_A, PUSH_ACC_B, PUSH_INDEX, WAIT_FOR_INTERRUPT};
	endproperty
	a_write_only_push: assert property (p_write_only_push) else $error("write outside stack push");

endmodule // inherent_mode_bus_sequencer

// ---- inherent_seq_pkg.sv ----
// Shared types and constants for the inherent-mode bus sequencer
package inherent_seq_pkg;

	localparam logic [15:0] IDLE_VECTOR_ADDR = 16'hFFFF;
	localparam logic [15:0] HALT_STACK_DROP  = 16'h0007;
	localparam logic [15:0] PULL_OFFSET_BASE = 16'h0003;
	localparam logic [15:0] STACK_COPY_ADJ   = 16'h0001;
	localparam logic [15:0] RESET_ADDR       = 16'hFFFF;
	localparam logic [7:0]  RESET_DATA       = 8'h00;
	localparam logic [3:0]  STEP_RESET       = 4'h0;
	localparam logic [3:0]  STEP_FIRST       = 4'h1;

	localparam logic [3:0]  CYC_SIMPLE = 4'h2;
	localparam logic [3:0]  CYC_THREE  = 4'h3;
	localparam logic [3:0]  CYC_FOUR   = 4'h4;
	localparam logic [3:0]  CYC_FIVE   = 4'h5;
	localparam logic [3:0]  CYC_WAIT   = 4'h9;

	typedef enum logic [4:0] {
		SIMPLE_INHERENT,
		ADD_B_TO_INDEX,
		DOUBLE_ACC_SHIFT_LEFT,
		DOUBLE_ACC_SHIFT_RIGHT,
		INDEX_INCREMENT,
		INDEX_DECREMENT,
		INDEX_TO_STACK_COPY,
		STACK_TO_INDEX_COPY,
		STACK_POINTER_INCREMENT,
		STACK_POINTER_DECREMENT,
		PUSH_ACC_A,
		PUSH_ACC_B,
		PULL_ACC_A,
		PULL_ACC_B,
		PUSH_INDEX,
		PULL_INDEX,
		RETURN_FROM_SUBROUTINE,
		WAIT_FOR_INTERRUPT
	} inst_kind_t;

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] x;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  cc;
	} cpu_regs_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rw;
		logic        oe;
		logic [7:0]  data;
	} bus_cycle_t;

endpackage

// ---- stack_memory_model.sv ----
// Byte memory serving opcode fetches and stack traffic
`timescale 1ns/1ps
module stack_memory_model
	import inherent_seq_pkg::*;
(
	input  wire logic  ref_clk,
	input  bus_cycle_t busOut,
	output logic [7:0] busDataIn
);
	logic [7:0] mem [0:65535];
	logic [7:0] lastData;

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ 8'h5A;
		end
		lastData = 8'h00;
	end

	// Read data on read cycles, otherwise a changing pattern
	always_comb busDataIn = busOut.rw ? mem[busOut.addr] : ~lastData;

	always @(posedge ref_clk) begin
		lastData <= busDataIn;
		if (!busOut.rw && busOut.oe) begin
			mem[busOut.addr] <= busOut.data;
		end
	end
endmodule // stack_memory_model

// ---- tb.sv ----
// Self-checking bench for the inherent-mode bus sequencer
`timescale 1ns/1ps
module tb;
	import inherent_seq_pkg::*;
	localparam logic [15:0] PC = 16'h1000;
	localparam logic [15:0] SP = 16'h0200;
	localparam logic [15:0] X  = 16'h3C5A;
	logic       ref_clk   = 1'b0;
	logic       rst_n     = 1'b0;
	logic       startReq  = 1'b0;
	inst_kind_t startKind = SIMPLE_INHERENT;
	cpu_regs_t  startRegs = '0;
	logic       wakeReq   = 1'b0;
	logic [7:0] busDataIn;
	bus_cycle_t busOut;
	logic       readyOut;
	logic       doneOut;
	cpu_regs_t  regsOut;
	int         error_cnt  = 0;
	int         num_checks = 0;

	always #5 ref_clk = ~ref_clk;

	inherent_mode_bus_sequencer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .startReq(startReq),
		.startKind(startKind), .startRegs(startRegs), .busDataIn(busDataIn), .wakeReq(wakeReq),
		.busOut(busOut), .readyOut(readyOut), .doneOut(doneOut), .regsOut(regsOut));
	stack_memory_model mem_u (.ref_clk(ref_clk), .busOut(busOut), .busDataIn(busDataIn));

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One bus cycle as seen mid-cycle
	task automatic cyc(input logic [15:0] addr, input logic rw, input logic [7:0] data);
		@(negedge ref_clk);
		startReq = 1'b0;
		chk("addr", busOut.addr, addr);
		chk("rw", busOut.rw, rw);
		chk("oe", busOut.oe, !rw);
		if (!rw) chk("wdata", busOut.data, data);
		chk("done", doneOut, 1'b0);
	endtask

	// Start in the current cycle, then opcode and next-address reads
	task automatic head(input inst_kind_t k);
		chk("ready", readyOut, 1'b1);
		startReq = 1'b1;
		startKind = k;
		startRegs = '{pc: PC, sp: SP, x: X, a: 8'h11, b: 8'h22, cc: 8'h33};
		cyc(PC, 1'b1, 8'h00);
		cyc(PC + 16'h0001, 1'b1, 8'h00);
	endtask

	task automatic fin(input logic [15:0] sp);
		@(negedge ref_clk);
		chk("done", doneOut, 1'b1);
		chk("sp", regsOut.sp, sp);
	endtask

	task automatic t_simple;
		head(SIMPLE_INHERENT);
		fin(SP);
		chk("pc", regsOut.pc, PC + 16'h0001);
	endtask

	task automatic t_ffff;
		inst_kind_t ks [6] = '{ADD_B_TO_INDEX, DOUBLE_ACC_SHIFT_LEFT, DOUBLE_ACC_SHIFT_RIGHT,
			INDEX_INCREMENT, INDEX_DECREMENT, INDEX_TO_STACK_COPY};
		logic [15:0] xs [6] = '{16'h3C7C, X, X, 16'h3C5B, 16'h3C59, X};
		logic [15:0] abExp [6] = '{16'h1122, 16'h2244, 16'h0891, 16'h1122, 16'h1122, 16'h1122};
		for (int i = 0; i < 6; i++) begin
			head(ks[i]);
			cyc(IDLE_VECTOR_ADDR, 1'b1, 8'h00);
			fin(ks[i] == INDEX_TO_STACK_COPY ? X - 16'h0001 : SP);
			chk("x", regsOut.x, xs[i]);
			chk("ab", {regsOut.a, regsOut.b}, abExp[i]);
		end
	endtask

	task automatic t_stack_read;
		head(STACK_POINTER_INCREMENT);
		cyc(SP, 1'b1, 8'h00);
		fin(SP + 16'h0001);
		head(STACK_POINTER_DECREMENT);
		cyc(SP, 1'b1, 8'h00);
		fin(SP - 16'h0001);
		head(STACK_TO_INDEX_COPY);
		cyc(SP, 1'b1, 8'h00);
		fin(SP);
		chk("x", regsOut.x, SP + 16'h0001);
	endtask

	task automatic t_push;
		head(PUSH_ACC_A);
		cyc(SP, 1'b0, 8'h11);
		fin(SP - 16'h0001);
		head(PUSH_ACC_B);
		cyc(SP, 1'b0, 8'h22);
		fin(SP - 16'h0001);
		chk("mem", {8'h00, mem_u.mem[SP]}, 16'h0022);
		head(PUSH_INDEX);
		cyc(SP, 1'b0, X[7:0]);
		cyc(SP - 16'h0001, 1'b0, X[15:8]);
		fin(SP - 16'h0002);
	endtask

	task automatic t_pull;
		mem_u.mem[SP + 16'h0001] = 8'hBE;
		mem_u.mem[SP + 16'h0002] = 8'hEF;
		head(PULL_ACC_A);
		cyc(SP, 1'b1, 8'h00);
		cyc(SP + 16'h0001, 1'b1, 8'h00);
		fin(SP + 16'h0001);
		chk("a", {8'h00, regsOut.a}, 16'h00BE);
		head(PULL_ACC_B);
		cyc(SP, 1'b1, 8'h00);
		cyc(SP + 16'h0001, 1'b1, 8'h00);
		fin(SP + 16'h0001);
		chk("b", {8'h00, regsOut.b}, 16'h00BE);
		head(PULL_INDEX);
		cyc(SP, 1'b1, 8'h00);
		cyc(SP + 16'h0001, 1'b1, 8'h00);
		cyc(SP + 16'h0002, 1'b1, 8'h00);
		fin(SP + 16'h0002);
		chk("x", regsOut.x, 16'hBEEF);
		head(RETURN_FROM_SUBROUTINE);
		cyc(SP, 1'b1, 8'h00);
		cyc(SP + 16'h0001, 1'b1, 8'h00);
		cyc(SP + 16'h0002, 1'b1, 8'h00);
		fin(SP + 16'h0002);
		chk("pc", regsOut.pc, 16'hBEEF);
	endtask

	task automatic t_wait;
		logic [7:0] ds [7] = '{8'h01, 8'h10, X[7:0], X[15:8], 8'h11, 8'h22, 8'h33};
		int n;
		head(WAIT_FOR_INTERRUPT);
		for (int i = 0; i < 7; i++) begin
			cyc(SP - 16'(i), 1'b0, ds[i]);
		end
		repeat (3) cyc(SP - HALT_STACK_DROP, 1'b1, 8'h00);
		wakeReq = 1'b1;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (doneOut !== 1'b1 && n < 4);
		wakeReq = 1'b0;
		chk("wake", doneOut, 1'b1);
		chk("sp", regsOut.sp, SP - HALT_STACK_DROP);
		chk("pc", regsOut.pc, PC + 16'h0001);
		chk("cc", {8'h00, regsOut.cc}, 16'h0033);
		if (doneOut !== 1'b1) report_and_stop();
	endtask

	initial begin
		repeat (12) @(negedge ref_clk);
		chk("rst addr", busOut.addr, RESET_ADDR);
		chk("rst ready", readyOut, 1'b1);
		chk("rst done", doneOut, 1'b0);
		chk("rst pc", regsOut.pc, 16'h0000);
		rst_n = 1'b1;
		@(negedge ref_clk);
		t_simple();
		t_ffff();
		t_stack_read();
		t_push();
		t_pull();
		t_wait();
		report_and_stop();
	end
endmodule // tb
